// ### rtl/bot_sequencer.sv
// Bulk-only transport sequencer for the first bulk host channel
//
// What this block does
// - Works only on the first bulk channel, with FIFO area one joined.
// - A new run starts when the phase field reads idle 00b.
// - Command phase sends 31 bytes from command area as bulk OUT.
// - Flags bit 7 clear: send FIFO data OUT up to transfer length.
// - Flags bit 7 set: issue bulk IN, write data to FIFO.
// - IN data ends at transfer length or on a short packet.
// - Zero transfer length skips data phase, goes to status.
// - OUT data stalls while FIFO holds nothing to send.
// - IN data stalls while FIFO lacks space; firmware drains it.
// - Status phase reads reply into status area, records byte count.
// - Status follows OUT data directly, IN data only once FIFO empty.
// - Reply must be 13 bytes, right signature, matching tag, status 0.
// - Failed reply check clears run, halts, raises stop flag.
// - Good status completion clears run and raises done flag.
// - Transaction error: clear run, stop flag, phase, code, cond flag.
// - Abort reports only after processing ends; done if status finished.
// - Abort before status finished raises stop, phase shows interrupted.
// - Writing a phase then setting run resumes that phase.
// - Hardware owns run, toggle, type, size, endpoint, length fields.
// - Toggles load from firmware, then track the live data toggle.
`default_nettype none
module bot_sequencer
  import bot_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        runSet,
  input  wire logic        runClr,
  input  wire logic        phaseWr,
  input  wire logic [1:0]  phaseWrVal,
  input  wire logic        togWr,
  input  wire logic        outTogInit,
  input  wire logic        inTogInit,
  input  wire logic [3:0]  outEp,
  input  wire logic [3:0]  inEp,
  input  wire logic [10:0] maxPkt,
  input  wire logic        fifoHasData,
  input  wire logic        fifoRoom,
  input  wire logic        fifoEmpty,
  input  wire bot_res_s    res,
  input  wire bot_tap_s    tap,
  input  wire bot_flag_s   flagClr,
  output bot_flag_s        flags,
  output logic             botRun,
  output logic [1:0]       transportPhase,
  output logic [3:0]       resultCode,
  output logic [10:0]      statusRxCount,
  output logic             outToggle,
  output logic             inToggle,
  output logic             txnRun,
  output bot_txn_s         txn,
  output logic [31:0]      remainingLength
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DRAIN} bot_st_e;

  bot_st_e     st;
  bot_st_e     next_st;
  logic [1:0]  next_phase;
  logic        next_run;
  bot_flag_s   next_flags;
  logic [3:0]  next_resultCode;
  logic [10:0] next_statusRxCount;
  logic        next_outToggle;
  logic        next_inToggle;
  logic        next_txnRun;
  bot_txn_s    next_txn;
  logic [31:0] next_remaining;
  logic        dataIn;
  logic        next_dataIn;
  logic [31:0] cbwTag;
  logic [31:0] next_cbwTag;
  logic [4:0]  byteIdx;
  logic [4:0]  next_byteIdx;
  logic        abortPend;
  logic        next_abortPend;
  logic        cswClr;
  logic        cswTapEn;
  logic        cswMatch;
  logic        stop;
  logic [1:0]  startPhase;
  logic [10:0] pktLen;
  logic [31:0] remLeft;

  bot_csw_check u_csw (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .clr    (cswClr),
    .tapEn  (cswTapEn),
    .idx    (byteIdx),
    .data   (tap.data),
    .expTag (cbwTag),
    .match  (cswMatch)
  );

  always_comb begin
    next_st            = st;
    next_phase         = transportPhase;
    next_run           = botRun;
    next_flags         = flags & ~flagClr;
    next_resultCode    = resultCode;
    next_statusRxCount = statusRxCount;
    next_outToggle     = outToggle;
    next_inToggle      = inToggle;
    next_txnRun        = txnRun;
    next_txn           = txn;
    next_remaining     = remainingLength;
    next_dataIn        = dataIn;
    next_cbwTag        = cbwTag;
    next_byteIdx       = byteIdx;
    next_abortPend     = abortPend;
    cswClr             = 1'b0;
    cswTapEn           = 1'b0;
    stop               = abortPend | runClr;
    startPhase         = phaseWr ? phaseWrVal : transportPhase;
    // Packet is the smaller of what is left and the max packet size
    pktLen = (remainingLength < {21'h0, maxPkt}) ?
             remainingLength[10:0] : maxPkt;
    remLeft = remainingLength - {21'h0, res.count};

    // Block bytes seen while a transaction of ours is outstanding
    if (tap.valid && st == ST_WAIT) begin
      next_byteIdx = byteIdx + 5'h01;
      if (transportPhase == PH_CMD) begin
        if (byteIdx[4:2] == CBW_TAG_POS[4:2]) begin
          next_cbwTag[{byteIdx[1:0], 3'h0} +: 8] = tap.data;
        end
        if (byteIdx[4:2] == CBW_LEN_POS[4:2]) begin
          next_remaining[{byteIdx[1:0], 3'h0} +: 8] = tap.data;
        end
        if (byteIdx == CBW_FLAG_POS) begin
          next_dataIn = tap.data[CBW_DIR_BIT];
        end
      end
      cswTapEn = (transportPhase == PH_STAT);
    end

    case (st)
      ST_IDLE: begin
        if (phaseWr) begin
          next_phase = phaseWrVal;
        end
        if (togWr) begin
          next_outToggle = outTogInit;
          next_inToggle  = inTogInit;
        end
        if (runSet) begin
          next_run       = 1'b1;
          next_abortPend = 1'b0;
          next_st        = ST_ISSUE;
          if (startPhase == PH_IDLE) begin
            next_phase = PH_CMD;
          end else begin
            next_phase = startPhase;
          end
        end
      end
      ST_ISSUE: begin
        next_txn.sizeUnlimited = 1'b0;
        if (runClr) begin
          next_run        = 1'b0;
          next_flags.halt = 1'b1;
          next_st         = ST_IDLE;
        end else begin
          case (transportPhase)
            PH_CMD: begin
              next_txn.dirIn         = 1'b0;
              next_txn.endpointIndex = outEp;
              next_txn.toggle        = outToggle;
              next_txn.area          = AREA_CBW;
              next_txn.len           = CBW_LEN;
              next_txnRun            = 1'b1;
              next_byteIdx           = 5'h00;
              next_st                = ST_WAIT;
            end
            PH_DATA: begin
              if (remainingLength == LENGTH_RST) begin
                next_phase = PH_STAT;
                next_st    = dataIn ? ST_DRAIN : ST_ISSUE;
              end else if (dataIn ? fifoRoom : fifoHasData) begin
                next_txn.dirIn         = dataIn;
                next_txn.endpointIndex = dataIn ? inEp : outEp;
                next_txn.toggle        = dataIn ? inToggle : outToggle;
                next_txn.area          = AREA_DATA;
                next_txn.len           = pktLen;
                next_txnRun            = 1'b1;
                next_byteIdx           = 5'h00;
                next_st                = ST_WAIT;
              end
            end
            PH_STAT: begin
              next_txn.dirIn         = 1'b1;
              next_txn.endpointIndex = inEp;
              next_txn.toggle        = inToggle;
              next_txn.area          = AREA_CSW;
              next_txn.len           = CSW_LEN;
              next_txnRun            = 1'b1;
              next_byteIdx           = 5'h00;
              cswClr                 = 1'b1;
              next_st                = ST_WAIT;
            end
            default: begin
              next_phase = PH_CMD;
            end
          endcase
        end
      end
      ST_WAIT: begin
        // Abort waits for the outstanding transaction to end
        if (runClr) begin
          next_abortPend = 1'b1;
        end
        if (res.done) begin
          next_txnRun = 1'b0;
          if (!res.ack) begin
            next_run        = 1'b0;
            next_flags.halt = 1'b1;
            next_flags.cond = 1'b1;
            next_resultCode = res.code;
            next_st         = ST_IDLE;
          end else begin
            if (txn.dirIn) begin
              next_inToggle = ~inToggle;
            end else begin
              next_outToggle = ~outToggle;
            end
            next_st = ST_ISSUE;
            case (transportPhase)
              PH_CMD: begin
                // Length bytes arrive before the answer, so it is final
                next_phase = (remainingLength == LENGTH_RST) ?
                             PH_STAT : PH_DATA;
              end
              PH_DATA: begin
                next_remaining = remLeft;
                if (dataIn && res.count < txn.len) begin
                  next_phase = PH_STAT;
                  next_st    = ST_DRAIN;
                end else if (remLeft == LENGTH_RST) begin
                  next_phase = PH_STAT;
                  next_st    = dataIn ? ST_DRAIN : ST_ISSUE;
                end
              end
              default: begin
                next_statusRxCount = res.count;
                next_run           = 1'b0;
                next_st            = ST_IDLE;
                if (res.count == CSW_LEN && cswMatch) begin
                  next_flags.done = 1'b1;
                end else begin
                  next_flags.halt = 1'b1;
                end
              end
            endcase
            if (stop && next_st != ST_IDLE) begin
              next_run        = 1'b0;
              next_flags.halt = 1'b1;
              next_st         = ST_IDLE;
            end
          end
        end
      end
      ST_DRAIN: begin
        if (runClr) begin
          next_run        = 1'b0;
          next_flags.halt = 1'b1;
          next_st         = ST_IDLE;
        end else if (fifoEmpty) begin
          next_st = ST_ISSUE;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st              <= ST_IDLE;
      transportPhase  <= PHASE_RST;
      botRun          <= 1'b0;
      flags           <= '0;
      resultCode      <= RESULT_RST;
      statusRxCount   <= COUNT_RST;
      outToggle       <= 1'b0;
      inToggle        <= 1'b0;
      txnRun          <= 1'b0;
      txn             <= '0;
      remainingLength <= LENGTH_RST;
      dataIn          <= 1'b0;
      cbwTag          <= LENGTH_RST;
      byteIdx         <= 5'h00;
      abortPend       <= 1'b0;
    end else if (ce) begin
      st              <= next_st;
      transportPhase  <= next_phase;
      botRun          <= next_run;
      flags           <= next_flags;
      resultCode      <= next_resultCode;
      statusRxCount   <= next_statusRxCount;
      outToggle       <= next_outToggle;
      inToggle        <= next_inToggle;
      txnRun          <= next_txnRun;
      txn             <= next_txn;
      remainingLength <= next_remaining;
      dataIn          <= next_dataIn;
      cbwTag          <= next_cbwTag;
      byteIdx         <= next_byteIdx;
      abortPend       <= next_abortPend;
    end
  end

  // Frozen cycles cancel pending checks rather than stretch them
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || !ce);

  chk_cmd_block: assert property (
    (txnRun && transportPhase == PH_CMD) |-> (!txn.dirIn &&
      txn.len == CBW_LEN && txn.area == AREA_CBW))
    else $error("command block transaction malformed");

  chk_data_dir: assert property (
    (txnRun && transportPhase == PH_DATA) |->
      (txn.dirIn == dataIn && txn.area == AREA_DATA))
    else $error("data transaction direction wrong");

  chk_zero_skip: assert property (
    (st == ST_WAIT && transportPhase == PH_CMD && res.done && res.ack &&
     remainingLength == LENGTH_RST && !stop) |=>
      (transportPhase == PH_STAT && st == ST_ISSUE))
    else $error("zero length did not skip data phase");

  chk_out_stall: assert property (
    ($rose(txnRun) && transportPhase == PH_DATA && !dataIn) |->
      $past(fifoHasData))
    else $error("OUT issued with empty FIFO");

  chk_in_stall: assert property (
    ($rose(txnRun) && transportPhase == PH_DATA && dataIn) |->
      $past(fifoRoom))
    else $error("IN issued without FIFO room");

  chk_drain_gate: assert property (
    (st == ST_DRAIN && !fifoEmpty && !runClr) |=> (st == ST_DRAIN && !txnRun))
    else $error("status began before FIFO emptied");

  chk_status_end: assert property (
    (st == ST_WAIT && transportPhase == PH_STAT && res.done && res.ack) |=>
      (statusRxCount == $past(res.count) && !botRun &&
       (flags.done != flags.halt || $past(flags.done || flags.halt))))
    else $error("status phase end wrong");

  chk_bad_len: assert property (
    (st == ST_WAIT && transportPhase == PH_STAT && res.done && res.ack &&
     res.count != CSW_LEN && !flagClr.halt) |=> (flags.halt && !botRun))
    else $error("short status reply not stopped");

  chk_err_stop: assert property (
    (st == ST_WAIT && res.done && !res.ack && !flagClr.halt &&
     !flagClr.cond) |=> (!botRun && flags.halt && flags.cond &&
      resultCode == $past(res.code) &&
      transportPhase == $past(transportPhase)))
    else $error("transaction error not reported");

  chk_out_toggle: assert property (
    (st == ST_WAIT && res.done && res.ack && !txn.dirIn) |=>
      (outToggle != $past(outToggle) && inToggle == $past(inToggle)))
    else $error("OUT toggle not flipped");

  cov_done: cover property (
    (st == ST_WAIT && transportPhase == PH_STAT && res.done) ##1 flags.done);
  cov_drain: cover property (st == ST_DRAIN ##1 st == ST_ISSUE);
  cov_error: cover property (st == ST_WAIT && res.done && !res.ack);
  cov_abort: cover property (st == ST_WAIT && runClr);
endmodule
`default_nettype wire

// ### rtl/bot_pkg.sv
// Constants and carrier types for the bulk-only transport sequencer
`default_nettype none
package bot_pkg;
  // Transport phase codes; idle must be zero
  localparam logic [1:0]  PH_IDLE      = 2'h0;
  localparam logic [1:0]  PH_CMD       = 2'h1;
  localparam logic [1:0]  PH_DATA      = 2'h2;
  localparam logic [1:0]  PH_STAT      = 2'h3;
  // FIFO area selected for a transaction
  localparam logic [1:0]  AREA_CBW     = 2'h1;
  localparam logic [1:0]  AREA_DATA    = 2'h2;
  localparam logic [1:0]  AREA_CSW     = 2'h3;
  // Block sizes in bytes, status signature and good status byte
  localparam logic [10:0] CBW_LEN      = 11'h01F;
  localparam logic [10:0] CSW_LEN      = 11'h00D;
  localparam logic [31:0] CSW_SIG      = 32'h53425355;
  localparam logic [7:0]  CSW_OK       = 8'h00;
  // Byte and bit positions inside the blocks
  localparam logic [4:0]  CBW_TAG_POS  = 5'h04;
  localparam logic [4:0]  CBW_LEN_POS  = 5'h08;
  localparam logic [4:0]  CBW_FLAG_POS = 5'h0C;
  localparam logic [2:0]  CBW_DIR_BIT  = 3'h7;
  localparam logic [4:0]  CSW_SIG_POS  = 5'h00;
  localparam logic [4:0]  CSW_TAG_POS  = 5'h04;
  localparam logic [4:0]  CSW_STAT_POS = 5'h0C;
  // Values after reset
  localparam logic [1:0]  PHASE_RST    = 2'h0;
  localparam logic [3:0]  RESULT_RST   = 4'h0;
  localparam logic [10:0] COUNT_RST    = 11'h000;
  localparam logic [31:0] LENGTH_RST   = 32'h00000000;

  typedef struct packed {
    logic        dirIn;
    logic [3:0]  endpointIndex;
    logic        toggle;
    logic [1:0]  area;
    logic        sizeUnlimited;
    logic [10:0] len;
  } bot_txn_s;

  typedef struct packed {
    logic        done;
    logic        ack;
    logic [3:0]  code;
    logic [10:0] count;
  } bot_res_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bot_tap_s;

  typedef struct packed {
    logic done;
    logic halt;
    logic cond;
  } bot_flag_s;
endpackage
`default_nettype wire

// ### rtl/bot_csw_check.sv
// Status block field checker for the bulk-only sequencer
`default_nettype none
module bot_csw_check
  import bot_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        tapEn,
  input  wire logic [4:0]  idx,
  input  wire logic [7:0]  data,
  input  wire logic [31:0] expTag,
  output logic             match
);
  logic       bad;
  logic       next_bad;
  logic       chk;
  logic [7:0] refByte;

  always_comb begin
    chk     = 1'b1;
    refByte = CSW_OK;
    if (idx[4:2] == CSW_SIG_POS[4:2]) begin
      refByte = CSW_SIG[{idx[1:0], 3'h0} +: 8];
    end else if (idx[4:2] == CSW_TAG_POS[4:2]) begin
      refByte = expTag[{idx[1:0], 3'h0} +: 8];
    end else if (idx != CSW_STAT_POS) begin
      chk = 1'b0;
    end
    // Sticky mismatch; a short reply is caught by the byte count
    next_bad = clr ? 1'b0 : (bad | (tapEn & chk & (data != refByte)));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bad <= 1'b0;
    end else if (ce) begin
      bad <= next_bad;
    end
  end

  assign match = ~bad;
endmodule
`default_nettype wire

// ### bench/bot_dev_model.sv
// Transaction engine and mass storage device model for the sequencer
`default_nettype none
module bot_dev_model
  import bot_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        txnRun,
  input  wire bot_txn_s    txn,
  input  wire logic [31:0] cbwTag,
  input  wire logic [31:0] cbwLen,
  input  wire logic        cbwDirIn,
  input  wire logic [2:0]  cswMode,
  input  wire logic        inShort,
  input  wire logic [1:0]  errArea,
  input  wire logic [3:0]  errCode,
  input  wire logic [7:0]  lat,
  output var  bot_res_s    res,
  output var  bot_tap_s    tap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] blk [31];
  logic [7:0] last;
  int         n;

  task automatic put(input int i, input logic [31:0] v);
    blk[i] = v[7:0];
    blk[i+1] = v[15:8];
    blk[i+2] = v[23:16];
    blk[i+3] = v[31:24];
  endtask

  // Idle answer lines carry junk, never the last value
  task automatic serve();
    bot_txn_s    t;
    logic [10:0] cnt;
    t = txn;
    cnt = t.len;
    n = 0;
    for (int i = 0; i < 31; i++) blk[i] = 8'h00;
    if (t.area == AREA_CBW) begin
      put(0, 32'h43425355);
      put(4, cbwTag);
      put(8, cbwLen);
      blk[12] = {cbwDirIn, 7'h00};
      n = 31;
    end else if (t.area == AREA_CSW) begin
      put(0, (cswMode == 3'h1) ? ~CSW_SIG : CSW_SIG);
      put(4, (cswMode == 3'h2) ? ~cbwTag : cbwTag);
      blk[12] = (cswMode == 3'h3) ? 8'h01 : CSW_OK;
      n = (cswMode == 3'h4) ? 12 : 13;
      cnt = n[10:0];
    end else if (t.dirIn && inShort) begin
      cnt = t.len - 11'h001;
    end
    repeat (lat) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      tap = {1'b1, blk[i]};
      last = blk[i];
    end
    @(negedge mclk);
    tap = {1'b0, ~last};
    @(negedge mclk);
    res = {1'b1, errArea != t.area, (errArea == t.area) ? errCode : 4'h0, cnt};
    @(negedge mclk);
    res = {1'b0, 1'b1, 4'hA, ~cnt};
    while (txnRun) @(negedge mclk);
  endtask

  initial begin
    res = {1'b0, 1'b1, 4'hA, 11'h7FF};
    tap = {1'b0, 8'hA5};
    last = 8'h5A;
    forever begin
      @(negedge mclk);
      if (rst_n && txnRun) serve();
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the bulk-only transport sequencer
`default_nettype none
module testbench
  import bot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0]  OEP  = 4'h2;
  localparam logic [3:0]  IEP  = 4'h9;
  localparam logic [10:0] MPKT = 11'h200;
  logic mclk, rst_n, ce, runSet, runClr, phaseWr, togWr;
  logic outTogInit, inTogInit, fifoHasData, fifoRoom, fifoEmpty;
  logic [1:0]  phaseWrVal, transportPhase, errArea;
  logic [3:0]  outEp, inEp, resultCode, errCode;
  logic [10:0] maxPkt, statusRxCount;
  logic [31:0] remainingLength, cbwTag, cbwLen;
  logic        botRun, outToggle, inToggle, txnRun, cbwDirIn, inShort;
  logic [2:0]  cswMode;
  logic [7:0]  lat;
  bot_res_s    res;
  bot_tap_s    tap;
  bot_flag_s   flagClr, flags;
  bot_txn_s    txn;
  int          error_cnt, check_count, i;
  logic [17:0] seen [$];
  logic        txnRunQ;

  bot_sequencer dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .runSet(runSet),
    .runClr(runClr), .phaseWr(phaseWr), .phaseWrVal(phaseWrVal),
    .togWr(togWr), .outTogInit(outTogInit), .inTogInit(inTogInit),
    .outEp(outEp), .inEp(inEp), .maxPkt(maxPkt), .fifoHasData(fifoHasData),
    .fifoRoom(fifoRoom), .fifoEmpty(fifoEmpty), .res(res), .tap(tap),
    .flagClr(flagClr), .flags(flags), .botRun(botRun),
    .transportPhase(transportPhase), .resultCode(resultCode),
    .statusRxCount(statusRxCount), .outToggle(outToggle),
    .inToggle(inToggle), .txnRun(txnRun), .txn(txn),
    .remainingLength(remainingLength));
  bot_dev_model dev (.mclk(mclk), .rst_n(rst_n), .txnRun(txnRun),
    .txn(txn), .cbwTag(cbwTag), .cbwLen(cbwLen), .cbwDirIn(cbwDirIn),
    .cswMode(cswMode), .inShort(inShort), .errArea(errArea),
    .errCode(errCode), .lat(lat), .res(res), .tap(tap));

  always #50 mclk = ~mclk;

  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask
  task automatic chkv(input logic [31:0] g, input logic [31:0] e,
                      input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask
  function automatic logic [17:0] ent(input logic d, input logic [1:0] a,
                                      input logic [10:0] l);
    return {d, d ? IEP : OEP, a, l};
  endfunction

  // Issue record, taken at the edge where the request first stands
  always @(posedge mclk) begin
    txnRunQ <= txnRun;
    if (txnRun && !txnRunQ) begin
      seen.push_back({txn.dirIn, txn.endpointIndex, txn.area, txn.len});
      chk1(txn.sizeUnlimited, 1'b0, "size unlimited set");
    end
  end

  task automatic start_run(input logic d, input logic [31:0] l);
    cbwDirIn = d;
    cbwLen = l;
    cbwTag = cbwTag + 32'h11;
    seen.delete();
    phaseWr = 1'b1;
    phaseWrVal = PH_IDLE;
    @(negedge mclk);
    phaseWr = 1'b0;
    @(negedge mclk);
    chkv(transportPhase, PH_IDLE, "phase not idle");
    runSet = 1'b1;
    @(negedge mclk);
    runSet = 1'b0;
    chk1(botRun, 1'b1, "run not set");
    chkv(transportPhase, PH_CMD, "not in command phase");
  endtask
  task automatic wait_idle();
    for (i = 0; i < 4000 && botRun !== 1'b0; i++) @(negedge mclk);
    if (botRun !== 1'b0) fail("run never ended");
  endtask
  task automatic wait_phase(input logic [1:0] p);
    for (i = 0; i < 4000 && transportPhase !== p; i++) @(negedge mclk);
    if (transportPhase !== p) fail("phase never reached");
  endtask
  task automatic pulse_clr();
    flagClr = '1;
    @(negedge mclk);
    flagClr = '0;
    @(negedge mclk);
    chkv(flags, 3'h0, "flags not cleared");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail("watchdog expired");
    tally_and_finish();
  end

  initial begin
    {mclk, rst_n, runSet, runClr, phaseWr, togWr} = '0;
    {outTogInit, inTogInit, fifoHasData, inShort, txnRunQ} = '0;
    {phaseWrVal, errArea, cswMode, lat, cbwLen, cbwDirIn} = '0;
    {error_cnt, check_count, i} = '0;
    ce = 1'b1;
    inTogInit = 1'b1;
    fifoRoom = 1'b1;
    fifoEmpty = 1'b1;
    outEp = OEP;
    inEp = IEP;
    maxPkt = MPKT;
    errCode = 4'h5;
    cbwTag = 32'hA5C30000;
    flagClr = '0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    chkv({botRun, flags, transportPhase, txnRun}, 7'h00, "reset values");
    togWr = 1'b1;
    @(negedge mclk);
    togWr = 1'b0;
    chkv({outToggle, inToggle}, 2'b01, "toggle load");
    // OUT run: starved, aborted, then resumed in the data phase
    start_run(1'b0, 32'd600);
    wait_phase(PH_DATA);
    repeat (10) @(negedge mclk);
    chkv(seen.size(), 1, "OUT issued with empty fifo");
    runClr = 1'b1;
    @(negedge mclk);
    runClr = 1'b0;
    @(negedge mclk);
    chkv({botRun, flags.halt, flags.done}, 3'b010, "abort flags");
    chkv(transportPhase, PH_DATA, "aborted phase");
    pulse_clr();
    fifoHasData = 1'b1;
    phaseWr = 1'b1;
    phaseWrVal = PH_DATA;
    runSet = 1'b1;
    @(negedge mclk);
    {phaseWr, runSet} = 2'b00;
    wait_idle();
    chkv({flags.done, flags.halt}, 2'b10, "OUT run end");
    chkv(statusRxCount, 32'd13, "status count");
    chkv({outToggle, inToggle}, 2'b10, "toggles after OUT");
    chkv(seen.size(), 4, "OUT txn count");
    chkv(seen[0], ent(1'b0, AREA_CBW, CBW_LEN), "command txn");
    chkv(seen[1], ent(1'b0, AREA_DATA, MPKT), "OUT pkt 1");
    chkv(seen[2], ent(1'b0, AREA_DATA, 11'd88), "OUT pkt 2");
    chkv(seen[3], ent(1'b1, AREA_CSW, CSW_LEN), "status txn");
    pulse_clr();
    // IN run: no room, short packet, status held until fifo empty
    fifoRoom = 1'b0;
    inShort = 1'b1;
    start_run(1'b1, 32'd1024);
    wait_phase(PH_DATA);
    repeat (10) @(negedge mclk);
    chkv(seen.size(), 1, "IN issued without room");
    fifoRoom = 1'b1;
    fifoEmpty = 1'b0;
    wait_phase(PH_STAT);
    repeat (10) @(negedge mclk);
    chkv(seen.size(), 2, "status before fifo empty");
    chkv(seen[1], ent(1'b1, AREA_DATA, MPKT), "IN pkt");
    fifoEmpty = 1'b1;
    wait_idle();
    chkv(seen.size(), 3, "IN txn count");
    chkv(remainingLength, 32'h00000201, "IN remaining");
    chkv(flags, 3'b100, "IN run end");
    inShort = 1'b0;
    pulse_clr();
    // Zero length runs over every status reply fault
    for (int m = 0; m < 5; m++) begin
      cswMode = m[2:0];
      start_run(1'b0, 32'd0);
      wait_idle();
      chkv(seen.size(), 2, "zero length txns");
      chkv(seen[1], ent(1'b1, AREA_CSW, CSW_LEN), "zero length");
      chkv({flags.done, flags.halt}, {m == 0, m != 0}, "csw");
      if (m == 4) chkv(statusRxCount, 32'd12, "short status");
      pulse_clr();
    end
    cswMode = 3'h0;
    // Refused OUT data transaction
    errArea = AREA_DATA;
    start_run(1'b0, 32'd100);
    wait_idle();
    chkv(flags, 3'b011, "error flags");
    chkv({transportPhase, resultCode}, {PH_DATA, 4'h5}, "err");
    errArea = 2'h0;
    pulse_clr();
    // Frozen clock enable ignores a run request
    ce = 1'b0;
    runSet = 1'b1;
    @(negedge mclk);
    {ce, runSet} = 2'b10;
    chk1(botRun, 1'b0, "run taken while frozen");
    // Abort while the status transaction is outstanding
    lat = 8'd20;
    start_run(1'b0, 32'd0);
    for (i = 0; i < 200 && txn.area !== AREA_CSW; i++) @(negedge mclk);
    chkv(txn.area, AREA_CSW, "no status txn");
    runClr = 1'b1;
    @(negedge mclk);
    runClr = 1'b0;
    chkv(flags, 3'b000, "flag before abort ends");
    for (i = 0; i < 200 && flags === 3'b000; i++) @(negedge mclk);
    chkv(flags, 3'b100, "abort after status");
    tally_and_finish();
  end
endmodule
`default_nettype wire
